// >>> bench/uart_interrupt_fifo_control_tb.sv
// bench: apb into host end, uart core levels into device end
// assumes hw/ sources compiled first
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_fifo_control_tb;
	import uic_pkg::*;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, rrst, trst;
	logic rxf = 1'b0, txe = 1'b0, herr0 = 1'b0, tick = 1'b0, rxa = 1'b0, ovr = 1'b0;
	logic fen, sre, pde, slv;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [4:0] rx_level = 5'h00;
	logic [3:0] dlt = 4'h0;
	int err_count = 0, samples_checked = 0, pulses = 0;
	uic_bus_if bus();
	uic_device uic_device_inst (.clk(clk), .srst(srst), .bus(bus), .rx_level(rx_level),
		.rx_holding_full(rxf), .tx_holding_empty(txe), .tx_below_trigger(txe), .overrun_now(ovr),
		.head_errors({2'b00, herr0}), .modem_deltas(dlt), .bit_tick(tick), .tx_room_flag(1'b0),
		.rx_avail_flag(rxa), .fifo_enable(fen), .rx_fifo_reset(rrst), .tx_fifo_reset(trst),
		.soft_reset_en(sre), .power_down_en(pde));
	uic_host uic_host_inst (.clk(clk), .srst(srst), .bus(bus), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slv));
	uic_bus_asserts uic_bus_asserts_inst (.clk(clk), .srst(srst), .addr(bus.addr), .rd(bus.rd),
		.wr(bus.wr), .wdata(bus.wdata), .rdata(bus.rdata), .irq(bus.irq));
	initial
	begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
		pulses <= pulses + (rrst === 1'b1) + (trst === 1'b1);
	task complete_run(input logic to);
		if (to)
			err_count++;
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			complete_run(1'b1);
	endtask
	task dev(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, 12'h000, {20'h0, d, w, a});
		n = 0;
		do apb(1'b0, 12'h004, 32'h0); while (r[0] !== 1'b0 && ++n < 20);
		if (n >= 20)
			complete_run(1'b1);
		apb(1'b0, 12'h008, 32'h0);
	endtask
	task rd(input logic [2:0] a, input logic [7:0] exp);
		dev(1'b0, a, 8'h00);
		chk(r[7:0], exp);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h01);
		$display("test reset done");
		dev(1'b1, 3'h2, 8'h46);
		rd(3'h2, 8'h01);
		rxf <= 1'b1;
		dev(1'b1, 3'h1, 8'h01);
		rd(3'h2, 8'h04);
		rxf <= 1'b0;
		rd(3'h2, 8'h01);
		dev(1'b1, 3'h2, 8'h47);
		chk(pulses[7:0], 8'h02);
		rd(3'h2, 8'hc1);
		$display("test setup done");
		herr0 <= 1'b1;
		dlt <= 4'h1;
		txe <= 1'b1;
		rxf <= 1'b1;
		rx_level <= 5'h04;
		dev(1'b1, 3'h1, 8'h0f);
		rd(3'h0, 8'h00);
		apb(1'b0, 12'h004, 32'h0);
		chk({7'h0, r[1]}, 8'h01);
		rd(3'h2, 8'hc6);
		rd(3'h5, 8'h00);
		rd(3'h2, 8'hc4);
		rx_level <= 5'h03;
		rd(3'h2, 8'hc2);
		txe <= 1'b0;
		dev(1'b1, 3'h0, 8'h55);
		rd(3'h2, 8'hc0);
		dlt <= 4'h0;
		rd(3'h6, 8'h00);
		rd(3'h2, 8'hc1);
		dev(1'b1, 3'h2, 8'hc1);
		rx_level <= 5'h0d;
		rd(3'h2, 8'hc1);
		rx_level <= 5'h0e;
		rd(3'h2, 8'hc4);
		$display("test priority done");
		herr0 <= 1'b0;
		rx_level <= 5'h01;
		dev(1'b1, 3'h1, 8'h01);
		tick <= 1'b1;
		repeat (51) @(posedge clk);
		tick <= 1'b0;
		rd(3'h2, 8'hc1);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		rd(3'h2, 8'hcc);
		rx_level <= 5'h00;
		rd(3'h0, 8'h00);
		rd(3'h2, 8'hc1);
		dev(1'b1, 3'h1, 8'h04);
		ovr <= 1'b1;
		@(posedge clk);
		ovr <= 1'b0;
		rd(3'h2, 8'hc6);
		rd(3'h5, 8'h00);
		rd(3'h2, 8'hc1);
		txe <= 1'b1;
		dev(1'b1, 3'h1, 8'h02);
		rd(3'h2, 8'hc2);
		rxa <= 1'b1;
		dev(1'b1, 3'h1, 8'h20);
		rd(3'h2, 8'hd1);
		rd(3'h1, 8'h20);
		chk({4'h0, slv, fen, sre, pde}, 8'h07);
		$display("test timeout and special done");
		complete_run(1'b0);
	end
endmodule // uart_interrupt_fifo_control_tb
`default_nettype wire

// >>> bench/uic_bus_asserts.sv
// checks on the register bus between host end and device end
// assumes instantiation beside uic_bus_if, same clk
`timescale 1ns/1ps
`default_nettype none
module uic_bus_asserts
(
	input wire logic clk,
	input wire logic srst,
	input wire uic_pkg::uic_addr_t addr,
	input wire logic rd,
	input wire logic wr,
	input wire uic_pkg::uic_byte_t wdata,
	input wire uic_pkg::uic_byte_t rdata,
	input wire logic irq
);
	import uic_pkg::*;
	logic [7:0] mask_ff;
	logic fen_ff;
	wire srd = rd && addr == 3'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	always_ff @(posedge clk)
	begin
		if (srst)
			mask_ff <= 8'h00;
		else if (wr && addr == 3'h1)
			mask_ff <= wdata & 8'h2f;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			fen_ff <= 1'b0;
		else if (wr && addr == 3'h2)
			fen_ff <= wdata[0];
	end
	a_reset_quiet: assert property ($fell(srst) |-> !irq)
		else $error("irq high after reset");
	a_mask_read: assert property (rd && addr == 3'h1 |=> rdata == $past(mask_ff))
		else $error("mask readback wrong");
	a_pending_bit: assert property (srd |=> rdata[0] == !$past(irq))
		else $error("source bit0 wrong");
	a_code_legal: assert property (srd |=> rdata[3:0] inside {4'h6, 4'hc, 4'h4, 4'h2, 4'h0, 4'h1})
		else $error("illegal source code");
	a_fifo_bits: assert property (srd |=> rdata[7:6] == {2{$past(fen_ff)}})
		else $error("fifo status bits wrong");
	a_line_masked: assert property (srd && !mask_ff[2] |=> rdata[3:0] != 4'h6)
		else $error("masked line source seen");
	a_modem_masked: assert property (srd && !mask_ff[3] |=> rdata[3:0] != 4'h0)
		else $error("masked modem source seen");
	a_special_off: assert property (srd && !mask_ff[5] |=> rdata[5:4] == 2'b00)
		else $error("dma bits shown outside special");
	a_none_quiet: assert property (mask_ff[3:0] == 4'h0 |-> !irq)
		else $error("irq with all sources off");
endmodule // uic_bus_asserts
`default_nettype wire

// >>> hw/uic_bus_if.sv
// parallel register bus between the uart block and its host
// assumes both ends on the same clk
`timescale 1ns/1ps
`default_nettype none
interface uic_bus_if;
	import uic_pkg::*;
	uic_addr_t addr;
	logic rd;
	logic wr;
	uic_byte_t wdata;
	uic_byte_t rdata;
	logic irq;
	modport dev (input addr, input rd, input wr, input wdata, output rdata, output irq);
	modport host (output addr, output rd, output wr, output wdata, input rdata, input irq);
endinterface
`default_nettype wire

// >>> hw/uic_consts.svh
// constants for the uart interrupt and fifo control block
// assumes inclusion by bare name from hw/ files
`ifndef UIC_CONSTS_SVH
`define UIC_CONSTS_SVH
`define UIC_OFS_MASK 3'h1
`define UIC_OFS_SOURCE 3'h2
`define UIC_OFS_SETUP 3'h2
`define UIC_OFS_LINE 3'h5
`define UIC_OFS_MODEM 3'h6
`define UIC_OFS_HOLD 3'h0
`define UIC_MASK_RXD 0
`define UIC_MASK_TXR 1
`define UIC_MASK_LINE 2
`define UIC_MASK_MODEM 3
`define UIC_MASK_SPECIAL 5
`define UIC_MASK_WMASK 8'h2f
`define UIC_SETUP_EN 0
`define UIC_SETUP_RXRST 1
`define UIC_SETUP_TXRST 2
`define UIC_SETUP_TRIG_LO 6
`define UIC_SETUP_TRIG_HI 7
`define UIC_CODE_LINE 4'h6
`define UIC_CODE_TMO 4'hc
`define UIC_CODE_RXD 4'h4
`define UIC_CODE_TXR 4'h2
`define UIC_CODE_MODEM 4'h0
`define UIC_CODE_NONE 4'h1
`define UIC_TRIG0 5'h01
`define UIC_TRIG1 5'h04
`define UIC_TRIG2 5'h08
`define UIC_TRIG3 5'h0e
`define UIC_TMO_CHARS 4
`define UIC_TMO_BITS 12
`define UIC_CHAR_BITS 10
`define UIC_CHAR_BITS_MIN 7
`define UIC_CHAR_BITS_MAX 12
`define UIC_RDATA_RST 8'h01
`define UIC_CMD_ADDR_HI 2
`define UIC_CMD_DIR 3
`define UIC_CMD_DATA_LO 4
`define UIC_CMD_DATA_HI 11
`define UIC_APB_CTRL 12'h000
`define UIC_APB_STAT 12'h004
`define UIC_APB_DATA 12'h008
`endif

// >>> hw/uic_device.sv
// uart interrupt enable, prioritised source and fifo setup
// assumes host drives one-cycle rd/wr strobes, uart core gives levels
//
// How it works
// - receive data interrupt on data or trigger
// - transmit ready when holding empty or below
// - enabling with holding empty raises it at once
// - line status interrupt on overrun/parity/framing/break
// - overrun immediate, other errors at readout
// - modem interrupt on any delta bit
// - special mode gates source bits and soft-reset/power-down enables
// - all enable bits zero after reset
// - source read shows only highest pending
// - fixed four-bit priority codes
// - timeout after four chars plus twelve bits
// - line condition read clears line interrupt
// - receive interrupt clears below trigger
// - timeout clears when receive fifo empties
// - transmit ready clears by holding write, or by source read while it is shown and holding is no longer empty or below
// - modem interrupt clears only when delta bits drop
// - bit zero low while anything pending
// - special mode shows inverted dma flags
// - bits seven and six show fifo enable
// - setup bit zero enables; others need it
// - receive fifo reset pulse, self clearing
// - transmit fifo reset pulse, self clearing
// - trigger levels 1, 4, 8, 14
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uic_consts.svh"
module uic_device
#(
	parameter int CHAR_BITS = `UIC_CHAR_BITS
)
(
	input wire logic clk,
	input wire logic srst,
	uic_bus_if.dev bus,
	input wire logic [4:0] rx_level,
	input wire logic rx_holding_full,
	input wire logic tx_holding_empty,
	input wire logic tx_below_trigger,
	input wire logic overrun_now,
	input wire logic [2:0] head_errors,
	input wire logic [3:0] modem_deltas,
	input wire logic bit_tick,
	input wire logic tx_room_flag,
	input wire logic rx_avail_flag,
	output logic fifo_enable,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic soft_reset_en,
	output logic power_down_en
);
	import uic_pkg::*;

	localparam int TMO_BITS = `UIC_TMO_CHARS * CHAR_BITS + `UIC_TMO_BITS;

	// six-bit timeout counter limits the character length
	if (CHAR_BITS < `UIC_CHAR_BITS_MIN || CHAR_BITS > `UIC_CHAR_BITS_MAX)
	begin : g_bad_char_bits
		$error("character length outside what the timeout counter serves");
	end

	logic [7:0] mask_ff;
	logic fifo_en_ff;
	logic [1:0] trig_ff;
	logic rxrst_ff;
	logic txrst_ff;
	logic line_ff;
	logic txr_ff;
	logic tmo_ff;
	logic [5:0] tmo_cnt_ff;
	logic [4:0] trig_lvl;
	logic rxd_src;
	logic line_src;
	logic modem_src;
	logic txr_src;
	logic tmo_src;
	logic [3:0] code;
	logic wr_mask;
	logic wr_setup;
	logic wr_hold;
	logic rd_src;
	logic rd_line;
	logic rd_hold;

	function automatic logic [4:0] trig_of(input logic [1:0] sel);
		case (sel)
			2'h0: trig_of = `UIC_TRIG0;
			2'h1: trig_of = `UIC_TRIG1;
			2'h2: trig_of = `UIC_TRIG2;
			default: trig_of = `UIC_TRIG3;
		endcase
	endfunction

	assign wr_mask = bus.wr && bus.addr == `UIC_OFS_MASK;
	assign wr_setup = bus.wr && bus.addr == `UIC_OFS_SETUP;
	assign wr_hold = bus.wr && bus.addr == `UIC_OFS_HOLD;
	assign rd_src = bus.rd && bus.addr == `UIC_OFS_SOURCE;
	assign rd_line = bus.rd && bus.addr == `UIC_OFS_LINE;
	assign rd_hold = bus.rd && bus.addr == `UIC_OFS_HOLD;

	// enable register
	always_ff @(posedge clk)
	begin
		if (srst)
			mask_ff <= 8'h00;
		else if (wr_mask)
			mask_ff <= bus.wdata & `UIC_MASK_WMASK;
	end

	// fifo setup
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fifo_en_ff <= 1'b0;
			trig_ff <= 2'h0;
			rxrst_ff <= 1'b0;
			txrst_ff <= 1'b0;
		end
		else
		begin
			rxrst_ff <= 1'b0;
			txrst_ff <= 1'b0;
			if (wr_setup)
			begin
				fifo_en_ff <= bus.wdata[`UIC_SETUP_EN];
				if (bus.wdata[`UIC_SETUP_EN])
				begin
					trig_ff <= bus.wdata[`UIC_SETUP_TRIG_HI:`UIC_SETUP_TRIG_LO];
					rxrst_ff <= bus.wdata[`UIC_SETUP_RXRST];
					txrst_ff <= bus.wdata[`UIC_SETUP_TXRST];
				end
			end
		end
	end

	assign trig_lvl = fifo_en_ff ? trig_of(trig_ff) : `UIC_TRIG0;

	assign rxd_src = mask_ff[`UIC_MASK_RXD] && (fifo_en_ff ? rx_level >= trig_lvl : rx_holding_full);

	// line status flag, set wins over clear
	always_ff @(posedge clk)
	begin
		if (srst)
			line_ff <= 1'b0;
		else if (overrun_now || (rd_hold && |head_errors))
			line_ff <= 1'b1;
		else if (rd_line)
			line_ff <= 1'b0;
	end
	assign line_src = mask_ff[`UIC_MASK_LINE] && line_ff;

	assign modem_src = mask_ff[`UIC_MASK_MODEM] && |modem_deltas;

	// transmit ready flag
	always_ff @(posedge clk)
	begin
		if (srst)
			txr_ff <= 1'b0;
		else if (wr_hold)
			txr_ff <= 1'b0;
		else if (fifo_en_ff ? tx_below_trigger : tx_holding_empty)
			txr_ff <= 1'b1;
		else if (rd_src && code == `UIC_CODE_TXR)
			txr_ff <= 1'b0;
	end
	assign txr_src = mask_ff[`UIC_MASK_TXR] && txr_ff;

	// receive timeout counter in bit times
	always_ff @(posedge clk)
	begin
		if (srst || rx_level == 5'h00 || rd_hold || rxrst_ff)
		begin
			tmo_cnt_ff <= 6'h00;
			tmo_ff <= 1'b0;
		end
		else if (bit_tick && !tmo_ff)
		begin
			if (tmo_cnt_ff == 6'(TMO_BITS - 1))
				tmo_ff <= 1'b1;
			else
				tmo_cnt_ff <= tmo_cnt_ff + 6'h01;
		end
	end
	assign tmo_src = mask_ff[`UIC_MASK_RXD] && fifo_en_ff && tmo_ff;

	// priority encode
	always_comb
	begin
		if (line_src)
			code = `UIC_CODE_LINE;
		else if (tmo_src)
			code = `UIC_CODE_TMO;
		else if (rxd_src)
			code = `UIC_CODE_RXD;
		else if (txr_src)
			code = `UIC_CODE_TXR;
		else if (modem_src)
			code = `UIC_CODE_MODEM;
		else
			code = `UIC_CODE_NONE;
	end

	// read data mux
	always_ff @(posedge clk)
	begin
		if (srst)
			bus.rdata <= `UIC_RDATA_RST;
		else if (bus.rd && bus.addr == `UIC_OFS_MASK)
			bus.rdata <= mask_ff;
		else if (rd_src)
			bus.rdata <= {{2{fifo_en_ff}},
				mask_ff[`UIC_MASK_SPECIAL] & ~rx_avail_flag,
				mask_ff[`UIC_MASK_SPECIAL] & ~tx_room_flag, code};
		else if (bus.rd)
			bus.rdata <= 8'h00;
	end

	assign bus.irq = code != `UIC_CODE_NONE;
	assign fifo_enable = fifo_en_ff;
	assign rx_fifo_reset = rxrst_ff;
	assign tx_fifo_reset = txrst_ff;
	assign soft_reset_en = mask_ff[`UIC_MASK_SPECIAL];
	assign power_down_en = mask_ff[`UIC_MASK_SPECIAL];
endmodule // uic_device
`default_nettype wire

// >>> hw/uic_host.sv
// host end: one register access per apb command
// assumes apb master of designer registers, one clk
`timescale 1ns/1ps
`default_nettype none
`include "uic_consts.svh"
module uic_host
(
	input wire logic clk,
	input wire logic srst,
	uic_bus_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import uic_pkg::*;

	uic_host_st_t st_ff;
	logic [`UIC_CMD_DATA_HI:0] ctrl_ff;
	logic [7:0] data_ff;
	logic [31:0] prdata_ff;
	logic busy;
	logic cmd_take;

	assign busy = st_ff != UIC_IDLE;
	assign cmd_take = !busy && psel && penable && pwrite && paddr == `UIC_APB_CTRL;

	// command register: addr, direction (1 = write), full write byte
	always_ff @(posedge clk)
	begin
		if (srst)
			st_ff <= UIC_IDLE;
		else
			case (st_ff)
				UIC_IDLE:
					if (cmd_take)
						st_ff <= UIC_RUN;
				UIC_RUN: st_ff <= UIC_DONE;
				UIC_DONE: st_ff <= UIC_IDLE;
				default: st_ff <= UIC_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			ctrl_ff <= '0;
		else if (cmd_take)
			ctrl_ff <= pwdata[`UIC_CMD_DATA_HI:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			data_ff <= 8'h00;
		else if (st_ff == UIC_DONE && !ctrl_ff[`UIC_CMD_DIR])
			data_ff <= bus.rdata; // read completes one cycle after strobe
	end

	// read data latched in the setup cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			prdata_ff <= 32'h0;
		else if (psel && !penable)
		begin
			case (paddr)
				`UIC_APB_STAT: prdata_ff <= {30'h0, bus.irq, busy};
				`UIC_APB_DATA: prdata_ff <= {24'h0, data_ff};
				default: prdata_ff <= {20'h0, ctrl_ff};
			endcase
		end
	end

	assign bus.addr = ctrl_ff[`UIC_CMD_ADDR_HI:0];
	assign bus.wr = st_ff == UIC_RUN && ctrl_ff[`UIC_CMD_DIR];
	assign bus.rd = st_ff == UIC_RUN && !ctrl_ff[`UIC_CMD_DIR];
	assign bus.wdata = ctrl_ff[`UIC_CMD_DATA_HI:`UIC_CMD_DATA_LO];
	assign pready = !(busy && paddr == `UIC_APB_CTRL && pwrite);
	assign pslverr = 1'b0;
	assign prdata = prdata_ff;
endmodule // uic_host
`default_nettype wire

// >>> hw/uic_pkg.sv
// types shared by the uart interrupt and fifo control ends
// assumes nothing beyond a systemverilog compiler
package uic_pkg;
	typedef logic [2:0] uic_addr_t;
	typedef logic [7:0] uic_byte_t;
	typedef enum logic [1:0] {UIC_IDLE, UIC_RUN, UIC_DONE} uic_host_st_t;
endpackage
